//--- dvc_regs.svh
/*
  Register offsets, field positions, reset values and step sizes of the
  DAC volume and range compressor block.
  Assumes 8-bit registers on a plain address/strobe port.
*/
// Overview of operation
// - Gain code is signed, half-dB, up to +24dB.
// - Code zero is unity and reset; ones is -0.5dB.
// - Code 0x81 is -63.5dB, 0x82 is -63dB.
// - Control bit 6 enables left compressor, reset on.
// - Control bit 5 enables right compressor, reset on.
// - Compressor runs only if playback block supports it.
// - Threshold -3 to -24 dBFS, reset -12.
// - Hysteresis 0 to 3 dB, reset 3.
// - Hold field zero disables hold, reset 0111.
// - Hold codes 1-5 give 32 to 512 words.
// - Hold codes 14, 15 give 4x, 5x 32768.
// - Attack rate 4dB halving per code step.
// - Decay rate 1.5625e-2dB halving per code step.
// - Right follows left gain when master selects so.
// - Gain changes soft-step per one or two words.
`ifndef DVC_REGS_SVH
`define DVC_REGS_SVH

`define DVC_ADDR_GAIN 8'h42
`define DVC_ADDR_RSVD 8'h43
`define DVC_ADDR_CTL1 8'h44
`define DVC_ADDR_HOLD 8'h45
`define DVC_ADDR_RATE 8'h46
`define DVC_ADDR_GAIN_NOW 8'h60
`define DVC_ADDR_RED_NOW 8'h61

`define DVC_RST_GAIN 8'h00
`define DVC_RST_RSVD 8'h00
`define DVC_RST_CTL1 8'h6f
`define DVC_RST_HOLD 8'h38
`define DVC_RST_RATE 8'h00
`define DVC_CTL1_WMASK 8'h7f
`define DVC_HOLD_WMASK 8'h78

`define DVC_BIT_EN_LEFT 6
`define DVC_BIT_EN_RIGHT 5
`define DVC_MASTER_R_FOLLOWS_L 2'h2
`define DVC_SOFT_EVERY 2'h0
`define DVC_SOFT_EVERY_2 2'h1
`define DVC_SOFT_OFF 2'h2

`define DVC_GAIN_MAX 8'h30
`define DVC_GAIN_MIN 8'h81
`define DVC_GAIN_RSVD_NEG 8'h80
`define DVC_CODE_OFFSET 8'h84
`define DVC_CODE_STEPS 8'h0c
`define DVC_SHIFT_BASE 5'h1a

`define DVC_HOLD_UNIT 18'h00020
`define DVC_HOLD_BIG 18'h08000
`define DVC_HOLD_LAST_SHIFT 4'hb
`define DVC_HOLD_BIG_BASE 4'ha

`define DVC_ATTACK_MAX 27'h0800000
`define DVC_DECAY_MAX 27'h0008000
`define DVC_RED_MAX 27'h7f00000
`define DVC_HALF_DB_SHIFT 20

`endif

//--- dvc_pkg.sv
/*
  Types and the shared gain scaling function of the DAC volume block.
  Assumes dvc_regs.svh is on the include path.
*/
`include "dvc_regs.svh"

package dvc_pkg;

  typedef struct packed {
    logic valid;
    logic signed [15:0] data;
  } dvc_smp_t;

  typedef struct packed {
    logic [2:0] thresh;
    logic [1:0] hyst;
    logic [17:0] hold_len;
    logic [3:0] attack;
    logic [3:0] decay;
  } dvc_cfg_t;

  typedef enum logic [3:0] {
    DVC_IDLE = 4'h1,
    DVC_ATTACK = 4'h2,
    DVC_HOLD = 4'h4,
    DVC_RELEASE = 4'h8
  } dvc_cmp_state_t;

  // Scales a sample by a signed half-dB code and saturates to full scale.
  function automatic logic signed [15:0] dvc_scale(input logic signed [15:0] x, input logic signed [7:0] code);
    logic [7:0] u;
    logic [3:0] q;
    logic [3:0] r;
    logic [16:0] m;
    logic signed [33:0] p;
    logic signed [33:0] s;
    logic [4:0] sh;
    u = 8'(8'(code) + `DVC_CODE_OFFSET);
    q = 4'(u / `DVC_CODE_STEPS);
    r = 4'(u % `DVC_CODE_STEPS);
    case (r)
      4'h1: m = 17'h0879c;
      4'h2: m = 17'h08fad;
      4'h3: m = 17'h09838;
      4'h4: m = 17'h0a145;
      4'h5: m = 17'h0aadc;
      4'h6: m = 17'h0b505;
      4'h7: m = 17'h0bfc9;
      4'h8: m = 17'h0cb30;
      4'h9: m = 17'h0d745;
      4'ha: m = 17'h0e412;
      4'hb: m = 17'h0f1a2;
      default: m = 17'h08000;
    endcase
    p = 34'(x * $signed({1'b0, m}));
    sh = 5'(`DVC_SHIFT_BASE - {1'b0, q});
    s = p >>> sh;
    if (s > 34'sh00007fff) begin
      return 16'sh7fff;
    end
    if (s < -34'sh000008000) begin
      return 16'sh8000;
    end
    return 16'(s);
  endfunction

endpackage : dvc_pkg

//--- dvc_compressor.sv
/*
  One channel of the dynamic range compressor, stepped once per word clock.
  Assumes a sample strobe at most once per clock and a steady configuration.
*/
`include "dvc_regs.svh"

module dvc_compressor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic en_i,
  input wire dvc_pkg::dvc_cfg_t cfg_i,
  input wire dvc_pkg::dvc_smp_t in_i,
  output dvc_pkg::dvc_smp_t out_o,
  output logic [7:0] red_code_o
);

  dvc_pkg::dvc_cmp_state_t state;
  dvc_pkg::dvc_cmp_state_t next_state;
  logic [26:0] red;
  logic [17:0] hold_cnt;
  logic [16:0] mag;
  logic [7:0] thr_db2;
  logic [7:0] rel_db2;
  logic signed [15:0] thr_lin;
  logic signed [15:0] rel_lin;
  logic over;
  logic under;
  logic [26:0] atk_step;
  logic [26:0] dec_step;

  // ----------------------------------------------------------------
  // Level detection
  // ----------------------------------------------------------------
  assign mag = in_i.data[15] ? 17'(-{in_i.data[15], in_i.data}) : {1'b0, in_i.data};
  assign thr_db2 = 8'(({5'h00, cfg_i.thresh} + 8'h01) * 8'h06);
  assign rel_db2 = 8'(thr_db2 + {5'h00, cfg_i.hyst, 1'b0});
  assign thr_lin = dvc_pkg::dvc_scale(16'sh7fff, $signed(8'(8'h00 - thr_db2)));
  assign rel_lin = dvc_pkg::dvc_scale(16'sh7fff, $signed(8'(8'h00 - rel_db2)));
  assign over = mag > {1'b0, thr_lin};
  assign under = mag < {1'b0, rel_lin};
  assign atk_step = `DVC_ATTACK_MAX >> cfg_i.attack;
  assign dec_step = `DVC_DECAY_MAX >> cfg_i.decay;
  assign red_code_o = 8'(red >> `DVC_HALF_DB_SHIFT);

  // ----------------------------------------------------------------
  // Gain reduction state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      dvc_pkg::DVC_IDLE: begin
        if (over) begin
          next_state = dvc_pkg::DVC_ATTACK;
        end
      end
      dvc_pkg::DVC_ATTACK: begin
        if (!over) begin
          next_state = (cfg_i.hold_len != 18'h00000) ? dvc_pkg::DVC_HOLD : dvc_pkg::DVC_RELEASE;
        end
      end
      dvc_pkg::DVC_HOLD: begin
        if (over) begin
          next_state = dvc_pkg::DVC_ATTACK;
        end else if (hold_cnt <= 18'h00001) begin
          next_state = dvc_pkg::DVC_RELEASE;
        end
      end
      dvc_pkg::DVC_RELEASE: begin
        if (over) begin
          next_state = dvc_pkg::DVC_ATTACK;
        end else if (under && red <= dec_step) begin
          next_state = dvc_pkg::DVC_IDLE;
        end
      end
      default: next_state = dvc_pkg::DVC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || !en_i) begin
      state <= dvc_pkg::DVC_IDLE;
    end else if (in_i.valid) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || !en_i) begin
      red <= 27'h0000000;
    end else if (in_i.valid && next_state == dvc_pkg::DVC_ATTACK) begin
      red <= (red > `DVC_RED_MAX - atk_step) ? `DVC_RED_MAX : red + atk_step;
    end else if (in_i.valid && next_state != dvc_pkg::DVC_HOLD && state == dvc_pkg::DVC_RELEASE && under) begin
      red <= (red > dec_step) ? red - dec_step : 27'h0000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || !en_i) begin
      hold_cnt <= 18'h00000;
    end else if (in_i.valid && state == dvc_pkg::DVC_ATTACK && next_state == dvc_pkg::DVC_HOLD) begin
      hold_cnt <= cfg_i.hold_len;
    end else if (in_i.valid && state == dvc_pkg::DVC_HOLD && hold_cnt != 18'h00000) begin
      hold_cnt <= hold_cnt - 18'h00001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_o <= '0;
    end else begin
      out_o.valid <= in_i.valid;
      out_o.data <= in_i.valid ? dvc_pkg::dvc_scale(in_i.data, $signed(8'(8'h00 - red_code_o))) : out_o.data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_comp_gate_off: assert property (@(posedge clk_i) disable iff (srst_i)
    !en_i |=> red == 27'h0000000 && state == dvc_pkg::DVC_IDLE) else $error("compressor active while gated");
  a_attack_add: assert property (@(posedge clk_i) disable iff (srst_i)
    en_i && in_i.valid && over && red <= `DVC_RED_MAX - atk_step |=> red == $past(red) + $past(atk_step))
    else $error("attack step wrong");
  a_decay_sub: assert property (@(posedge clk_i) disable iff (srst_i)
    en_i && in_i.valid && state == dvc_pkg::DVC_RELEASE && !over && under && red > dec_step
    |=> red == $past(red) - $past(dec_step)) else $error("decay step wrong");
  a_hold_load: assert property (@(posedge clk_i) disable iff (srst_i)
    en_i && in_i.valid && state == dvc_pkg::DVC_ATTACK && !over && cfg_i.hold_len != 18'h00000
    |=> state == dvc_pkg::DVC_HOLD && hold_cnt == $past(cfg_i.hold_len)) else $error("hold not loaded");
  a_hold_skip: assert property (@(posedge clk_i) disable iff (srst_i)
    en_i && in_i.valid && state == dvc_pkg::DVC_ATTACK && !over && cfg_i.hold_len == 18'h00000
    |=> state == dvc_pkg::DVC_RELEASE) else $error("hold not bypassed");

endmodule // dvc_compressor

//--- dvc_top.sv
/*
  DAC right channel digital volume with soft stepping and a two channel
  dynamic range compressor, with its register file.
  Assumes samples arrive at most one per clock, flagged once per word clock,
  and that the left volume and the DAC setup fields come from outside.
*/
`include "dvc_regs.svh"

module dvc_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] left_gain_i,
  input wire logic [1:0] master_vol_i,
  input wire logic [1:0] soft_step_i,
  input wire logic playback_block_choice_drc_i,
  input wire dvc_pkg::dvc_smp_t left_in_i,
  input wire dvc_pkg::dvc_smp_t right_in_i,
  output dvc_pkg::dvc_smp_t left_out_o,
  output dvc_pkg::dvc_smp_t right_out_o,
  output logic [7:0] right_gain_now_o
);

  logic [7:0] gain_reg;
  logic [7:0] rsvd_reg;
  logic [7:0] ctl1_reg;
  logic [7:0] hold_reg;
  logic [7:0] rate_reg;
  logic [7:0] cur_gain;
  logic [7:0] target_raw;
  logic [7:0] target;
  logic half_tick;
  logic step_ok;
  dvc_pkg::dvc_cfg_t cfg;
  logic [1:0] comp_en;
  dvc_pkg::dvc_smp_t ch_in [2];
  dvc_pkg::dvc_smp_t ch_gain [2];
  dvc_pkg::dvc_smp_t ch_out [2];
  logic [7:0] ch_code [2];
  logic [7:0] red_code [2];

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Hold length in word clocks; codes between the listed ends double up to
  // 32768 and then rise in 32768 word steps.
  function automatic logic [17:0] hold_words(input logic [3:0] c);
    if (c == 4'h0) begin
      return 18'h00000;
    end
    if (c <= `DVC_HOLD_LAST_SHIFT) begin
      return 18'(`DVC_HOLD_UNIT << (c - 4'h1));
    end
    return 18'(`DVC_HOLD_BIG * {14'h0000, 4'(c - `DVC_HOLD_BIG_BASE)});
  endfunction

  function automatic logic [7:0] clamp_code(input logic [7:0] c);
    if ($signed(c) > $signed(`DVC_GAIN_MAX)) begin
      return `DVC_GAIN_MAX;
    end
    if (c == `DVC_GAIN_RSVD_NEG) begin
      return `DVC_GAIN_MIN;
    end
    return c;
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      `DVC_ADDR_GAIN: return gain_reg;
      `DVC_ADDR_RSVD: return rsvd_reg;
      `DVC_ADDR_CTL1: return ctl1_reg;
      `DVC_ADDR_HOLD: return hold_reg;
      `DVC_ADDR_RATE: return rate_reg;
      `DVC_ADDR_GAIN_NOW: return cur_gain;
      `DVC_ADDR_RED_NOW: return red_code[1];
      default: return 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gain_reg <= `DVC_RST_GAIN;
      rsvd_reg <= `DVC_RST_RSVD;
      ctl1_reg <= `DVC_RST_CTL1;
      hold_reg <= `DVC_RST_HOLD;
      rate_reg <= `DVC_RST_RATE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `DVC_ADDR_GAIN: gain_reg <= reg_wdata_i;
        `DVC_ADDR_RSVD: rsvd_reg <= reg_wdata_i;
        `DVC_ADDR_CTL1: ctl1_reg <= reg_wdata_i & `DVC_CTL1_WMASK;
        `DVC_ADDR_HOLD: hold_reg <= reg_wdata_i & `DVC_HOLD_WMASK;
        `DVC_ADDR_RATE: rate_reg <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? read_mux(reg_addr_i) : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Soft-stepped right channel gain
  // ----------------------------------------------------------------
  assign target_raw = (master_vol_i == `DVC_MASTER_R_FOLLOWS_L) ? left_gain_i : gain_reg;
  assign target = clamp_code(target_raw);
  assign step_ok = right_in_i.valid && (soft_step_i != `DVC_SOFT_EVERY_2 || half_tick);
  assign right_gain_now_o = cur_gain;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      half_tick <= 1'b0;
    end else if (right_in_i.valid) begin
      half_tick <= !half_tick;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cur_gain <= `DVC_RST_GAIN;
    end else if (soft_step_i == `DVC_SOFT_OFF) begin
      cur_gain <= target;
    end else if (step_ok && $signed(cur_gain) < $signed(target)) begin
      cur_gain <= 8'(cur_gain + 8'h01);
    end else if (step_ok && $signed(cur_gain) > $signed(target)) begin
      cur_gain <= 8'(cur_gain - 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // Gain stage and compressors
  // ----------------------------------------------------------------
  assign cfg.thresh = ctl1_reg[4:2];
  assign cfg.hyst = ctl1_reg[1:0];
  assign cfg.hold_len = hold_words(hold_reg[6:3]);
  assign cfg.attack = rate_reg[7:4];
  assign cfg.decay = rate_reg[3:0];
  assign comp_en[0] = ctl1_reg[`DVC_BIT_EN_LEFT] && playback_block_choice_drc_i;
  assign comp_en[1] = ctl1_reg[`DVC_BIT_EN_RIGHT] && playback_block_choice_drc_i;
  assign ch_in[0] = left_in_i;
  assign ch_in[1] = right_in_i;
  assign ch_code[0] = 8'h00;
  assign ch_code[1] = cur_gain;
  assign left_out_o = ch_out[0];
  assign right_out_o = ch_out[1];

  // The left volume is applied upstream, so its gain stage is a unity delay
  // that keeps both channels aligned.
  for (genvar i = 0; i < 2; i++) begin : g_ch
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        ch_gain[i] <= '0;
      end else begin
        ch_gain[i].valid <= ch_in[i].valid;
        if (ch_in[i].valid) begin
          ch_gain[i].data <= dvc_pkg::dvc_scale(ch_in[i].data, $signed(ch_code[i]));
        end
      end
    end

    dvc_compressor u_comp (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .en_i(comp_en[i]),
      .cfg_i(cfg),
      .in_i(ch_gain[i]),
      .out_o(ch_out[i]),
      .red_code_o(red_code[i])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gain_reset_unity: assert property (@(posedge clk_i)
    srst_i |=> cur_gain == 8'h00 && gain_reg == 8'h00) else $error("gain not unity after reset");
  a_gain_unity_pass: assert property (@(posedge clk_i) disable iff (srst_i)
    right_in_i.valid && cur_gain == 8'h00 |=> ch_gain[1].data == $past(right_in_i.data))
    else $error("unity gain altered sample");
  a_gain_minus_half: assert property (@(posedge clk_i) disable iff (srst_i)
    right_in_i.valid && cur_gain == 8'hff && right_in_i.data == 16'sh4000
    |=> ch_gain[1].data == 16'sh3c68) else $error("minus half dB wrong");
  a_gain_top_sat: assert property (@(posedge clk_i) disable iff (srst_i)
    right_in_i.valid && cur_gain == 8'h30 && right_in_i.data == 16'sh1000
    |=> ch_gain[1].data == 16'sh7fff) else $error("plus 24 dB not saturated");
  a_gain_bottom: assert property (@(posedge clk_i) disable iff (srst_i)
    cur_gain != 8'h80) else $error("reserved gain code applied");
  a_soft_one_step: assert property (@(posedge clk_i) disable iff (srst_i)
    soft_step_i == `DVC_SOFT_EVERY && right_in_i.valid && cur_gain != target
    |=> (8'(cur_gain - $past(cur_gain)) == 8'h01) || (8'($past(cur_gain) - cur_gain) == 8'h01))
    else $error("soft step not one half dB");
  a_soft_off_jump: assert property (@(posedge clk_i) disable iff (srst_i)
    soft_step_i == `DVC_SOFT_OFF |=> cur_gain == $past(target)) else $error("gain not applied at once");
  a_follow_left: assert property (@(posedge clk_i) disable iff (srst_i)
    master_vol_i == `DVC_MASTER_R_FOLLOWS_L && soft_step_i == `DVC_SOFT_OFF && left_gain_i == 8'h30
    |=> cur_gain == 8'h30) else $error("right gain not following left");
  a_ctl_rsvd_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    reg_rd_i && (reg_addr_i == `DVC_ADDR_CTL1 || reg_addr_i == `DVC_ADDR_HOLD)
    |=> !reg_rdata_o[7]) else $error("reserved control bit set");
  a_hold_code_14: assert property (@(posedge clk_i) disable iff (srst_i)
    hold_reg[6:3] == 4'he |-> cfg.hold_len == 18'h20000) else $error("hold code 14 length wrong");
  a_hold_code_5: assert property (@(posedge clk_i) disable iff (srst_i)
    hold_reg[6:3] == 4'h5 |-> cfg.hold_len == 18'h00200) else $error("hold code 5 length wrong");
  a_comp_block_off: assert property (@(posedge clk_i) disable iff (srst_i)
    !playback_block_choice_drc_i |=> red_code[0] == 8'h00 && red_code[1] == 8'h00)
    else $error("compressor active without block support");

endmodule // dvc_top

//--- test_dac_volume_and_range_compressor.sv
/*
  Self-checking bench for the DAC right channel volume and range compressor.
  Assumes dvc_regs.svh and dvc_pkg are compiled first; left samples mirror the right ones.
*/
`include "dvc_regs.svh"

module test_dac_volume_and_range_compressor;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i;
  logic srst_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic [7:0] left_gain_i;
  logic [1:0] master_vol_i;
  logic [1:0] soft_step_i;
  logic playback_block_choice_drc_i;
  dvc_pkg::dvc_smp_t left_in_i;
  dvc_pkg::dvc_smp_t right_in_i;
  dvc_pkg::dvc_smp_t left_out_o;
  dvc_pkg::dvc_smp_t right_out_o;
  logic [7:0] right_gain_now_o;
  int err_count;
  int cmp_count;
  int cycles;

  dvc_top i_dut (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .left_gain_i(left_gain_i),
    .master_vol_i(master_vol_i),
    .soft_step_i(soft_step_i),
    .playback_block_choice_drc_i(playback_block_choice_drc_i),
    .left_in_i(left_in_i),
    .right_in_i(right_in_i),
    .left_out_o(left_out_o),
    .right_out_o(right_out_o),
    .right_gain_now_o(right_gain_now_o)
  );

  // ----------------------------------------------------------------
  // Clock, watchdog and reporting
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("unexpected at %0t: watchdog expired got %h expected %h", $time, cycles, 0);
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Register bus and sample drivers
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    reg_addr_i <= addr;
    reg_wdata_i <= data;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk_i);
    reg_addr_i <= addr;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check({8'h00, reg_rdata_o}, {8'h00, exp});
  endtask

  // Sends one sample on both channels; each result must appear exactly two cycles after it is driven.
  task automatic smp(input logic [15:0] x, input logic [15:0] exp, input bit chk);
    @(posedge clk_i);
    right_in_i <= {1'b1, x};
    left_in_i <= {1'b1, x};
    @(posedge clk_i);
    right_in_i.valid <= 1'b0;
    left_in_i.valid <= 1'b0;
    @(posedge clk_i);
    #1;
    check({15'h0000, right_out_o.valid}, 16'h0001);
    check({15'h0000, left_out_o.valid}, 16'h0001);
    if (chk) begin
      check(right_out_o.data, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    rd_chk(`DVC_ADDR_GAIN, 8'h00);
    rd_chk(`DVC_ADDR_RSVD, 8'h00);
    rd_chk(`DVC_ADDR_CTL1, 8'h6f);
    rd_chk(`DVC_ADDR_HOLD, 8'h38);
    rd_chk(`DVC_ADDR_RATE, 8'h00);
    reg_wr(8'h50, 8'hff);
    rd_chk(8'h50, 8'h00);
    $display("test reset done");
  endtask

  task automatic test_regs();
    reg_wr(`DVC_ADDR_CTL1, 8'h7f);
    rd_chk(`DVC_ADDR_CTL1, 8'h7f);
    reg_wr(`DVC_ADDR_HOLD, 8'h70);
    rd_chk(`DVC_ADDR_HOLD, 8'h70);
    reg_wr(`DVC_ADDR_HOLD, 8'h28);
    reg_wr(`DVC_ADDR_RSVD, 8'ha5);
    rd_chk(`DVC_ADDR_RSVD, 8'ha5);
    reg_wr(`DVC_ADDR_RATE, 8'h5a);
    rd_chk(`DVC_ADDR_RATE, 8'h5a);
    reg_wr(`DVC_ADDR_CTL1, 8'h6f);
    reg_wr(`DVC_ADDR_HOLD, 8'h38);
    reg_wr(`DVC_ADDR_RATE, 8'h00);
    $display("test registers done");
  endtask

  task automatic test_gain();
    logic [7:0] codes [8];
    logic [15:0] ins [8];
    logic [15:0] exps [8];
    codes = '{8'h00, 8'h30, 8'h30, 8'h30, 8'hff, 8'h82, 8'h81, 8'hf4};
    ins = '{16'h1234, 16'h0400, 16'h1000, 16'hf000, 16'h4000, 16'h4000, 16'h4000, 16'h4000};
    exps = '{16'h1234, 16'h4000, 16'h7fff, 16'h8000, 16'h3c68, 16'h000b, 16'h000a, 16'h2000};
    soft_step_i <= `DVC_SOFT_OFF;
    playback_block_choice_drc_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      reg_wr(`DVC_ADDR_GAIN, codes[i]);
      rd_chk(`DVC_ADDR_GAIN, codes[i]);
      check({8'h00, right_gain_now_o}, {8'h00, codes[i]});
      smp(ins[i], exps[i], 1'b1);
    end
    master_vol_i <= `DVC_MASTER_R_FOLLOWS_L;
    left_gain_i <= 8'h30;
    smp(16'h0400, 16'h4000, 1'b1);
    rd_chk(`DVC_ADDR_GAIN_NOW, 8'h30);
    check(left_out_o.data, 16'h0400);
    master_vol_i <= 2'h0;
    $display("test gain done");
  endtask

  task automatic test_soft();
    reg_wr(`DVC_ADDR_GAIN, 8'h00);
    @(posedge clk_i);
    soft_step_i <= `DVC_SOFT_EVERY;
    reg_wr(`DVC_ADDR_GAIN, 8'h04);
    @(posedge clk_i);
    #1;
    check({8'h00, right_gain_now_o}, 16'h0000);
    for (int i = 1; i <= 4; i++) begin
      smp(16'h0100, 16'h0000, 1'b0);
      check({8'h00, right_gain_now_o}, 16'(i));
    end
    soft_step_i <= `DVC_SOFT_EVERY_2;
    reg_wr(`DVC_ADDR_GAIN, 8'h00);
    repeat (4) smp(16'h0100, 16'h0000, 1'b0);
    check({8'h00, right_gain_now_o}, 16'h0002);
    soft_step_i <= `DVC_SOFT_OFF;
    reg_wr(`DVC_ADDR_GAIN, 8'h00);
    @(posedge clk_i);
    #1;
    check({8'h00, right_gain_now_o}, 16'h0000);
    $display("test soft step done");
  endtask

  task automatic test_drc();
    playback_block_choice_drc_i <= 1'b1;
    reg_wr(`DVC_ADDR_CTL1, 8'h63);
    smp(16'h5000, 16'h5000, 1'b1);
    rd_chk(`DVC_ADDR_RED_NOW, 8'h00);
    reg_wr(`DVC_ADDR_CTL1, 8'h6f);
    repeat (3) smp(16'h7fff, 16'h0000, 1'b0);
    rd_chk(`DVC_ADDR_RED_NOW, 8'h18);
    playback_block_choice_drc_i <= 1'b0;
    smp(16'h7fff, 16'h7fff, 1'b1);
    rd_chk(`DVC_ADDR_RED_NOW, 8'h00);
    playback_block_choice_drc_i <= 1'b1;
    reg_wr(`DVC_ADDR_CTL1, 8'h4f);
    repeat (2) smp(16'h7fff, 16'h7fff, 1'b1);
    rd_chk(`DVC_ADDR_RED_NOW, 8'h00);
    reg_wr(`DVC_ADDR_CTL1, 8'h6f);
    reg_wr(`DVC_ADDR_RATE, 8'h10);
    smp(16'h7fff, 16'h0000, 1'b0);
    smp(16'h7fff, 16'h6597, 1'b1);
    rd_chk(`DVC_ADDR_RED_NOW, 8'h08);
    reg_wr(`DVC_ADDR_HOLD, 8'h00);
    repeat (2) smp(16'h0100, 16'h0000, 1'b0);
    rd_chk(`DVC_ADDR_RED_NOW, 8'h07);
    reg_wr(`DVC_ADDR_RATE, 8'h80);
    smp(16'h7fff, 16'h0000, 1'b0);
    rd_chk(`DVC_ADDR_RED_NOW, 8'h08);
    reg_wr(`DVC_ADDR_HOLD, 8'h08);
    repeat (33) smp(16'h0100, 16'h0000, 1'b0);
    rd_chk(`DVC_ADDR_RED_NOW, 8'h08);
    smp(16'h0100, 16'h0000, 1'b0);
    rd_chk(`DVC_ADDR_RED_NOW, 8'h07);
    $display("test compressor done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    cmp_count = 0;
    cycles = 0;
    srst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    left_gain_i = 8'h00;
    master_vol_i = 2'h0;
    soft_step_i = `DVC_SOFT_OFF;
    playback_block_choice_drc_i = 1'b0;
    left_in_i = '0;
    right_in_i = '0;
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    test_regs();
    test_gain();
    test_soft();
    test_drc();
    tally_and_finish();
  end

endmodule // test_dac_volume_and_range_compressor
